// *** rtl/pmc_pkg.sv ***
package pmc_pkg;

    // Global power modes, highest consumption first
    typedef enum logic [1:0] {
        MODE_ACTIVE,
        MODE_ALT_ACTIVE,
        MODE_SLEEP,
        MODE_HIBERNATE
    } pmc_mode_type;

    // Register byte offsets
    localparam logic [7:0] OFF_MODE_SEL  = 8'h00;
    localparam logic [7:0] OFF_ACT_TMPL  = 8'h04;
    localparam logic [7:0] OFF_ALT_TMPL  = 8'h08;
    localparam logic [7:0] OFF_WAKE_EN   = 8'h0C;
    localparam logic [7:0] OFF_STATUS    = 8'h10;

    // Status field positions
    localparam int STAT_MODE_LSB   = 0;
    localparam int STAT_CPU_FORCE  = 2;
    localparam int STAT_RESUMING   = 3;
    localparam int STAT_WAKE_LSB   = 8;

    // Subsystem and wake source positions
    localparam int SUB_CPU         = 0;
    localparam int WAKE_COMPARATOR = 0;
    localparam int WAKE_PIN_IRQ    = 1;
    localparam int WAKE_I2C        = 2;
    localparam int WAKE_RTC        = 3;
    localparam int WAKE_TIME_WHEEL = 4;
    localparam int WAKE_LOW_VOLT   = 5;

    // Reset values
    localparam logic [31:0] RST_ACT_TMPL = 32'hFFFF_FFFF;
    localparam logic [31:0] RST_ALT_TMPL = 32'h0000_0000;
    localparam logic [31:0] RST_WAKE_EN  = 32'hFFFF_FFFF;

    // Timing
    localparam int CLK_MHZ           = 40;
    localparam int T_SLEEP_RESUME_NS = 15000;
    localparam int T_HIB_RESUME_NS   = 100000;
    // Least time rounds up, longest rounds down
    localparam int SLEEP_RESUME_CYC  = (T_SLEEP_RESUME_NS * CLK_MHZ + 999) / 1000;
    localparam int HIB_RESUME_CYC    = (T_HIB_RESUME_NS * CLK_MHZ) / 1000;
    localparam int BUZZ_PERIOD_CYC   = 64;
    localparam int BUZZ_ON_CYC       = 4;

endpackage

// *** rtl/pmc_buzz.sv ***
`timescale 1ns/1ps
module pmc_buzz #(
    parameter int PERIOD = pmc_pkg::BUZZ_PERIOD_CYC,
    parameter int ON_LEN = pmc_pkg::BUZZ_ON_CYC
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic run,
    output logic      pulse
);
    import pmc_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
        logic        pulse;
    } pmc_buzz_state_type;

    pmc_buzz_state_type s_ff;
    pmc_buzz_state_type nxt_s;

    always_comb begin
        nxt_s = s_ff;
        if (!run) begin
            // Restart phase so every sleep begins with a full pulse
            nxt_s.cnt   = 16'h0000;
            nxt_s.pulse = 1'b0;
        end else begin
            nxt_s.pulse = (s_ff.cnt < 16'(ON_LEN));
            if (s_ff.cnt == 16'(PERIOD - 1)) begin
                nxt_s.cnt = 16'h0000;
            end else begin
                nxt_s.cnt = s_ff.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign pulse = s_ff.pulse;
endmodule

// *** rtl/pmc_power_mode_ctrl.sv ***
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module pmc_power_mode_ctrl #(
    parameter int NSUB   = 8,
    parameter int NWAKE  = 6,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Wake sources, synchronous
    input  wire logic [NWAKE-1:0]      wake_src,
    // Subsystem, clock and regulator controls
    output logic      [NSUB-1:0]       subsys_en,
    output logic                       sys_clk_en,
    output logic                       lowspeed_clk_en,
    output logic                       time_wheel_run,
    output logic                       rtc_run,
    output logic                       dig_reg_en,
    output logic                       ana_reg_en,
    output logic                       hib_reg_en,
    output pmc_pkg::pmc_mode_type      mode_now
);
    import pmc_pkg::*;

    typedef enum logic [2:0] {
        ST_ACTIVE,
        ST_ALT,
        ST_ENTER,
        ST_SLEEP,
        ST_HIB,
        ST_RESUME
    } pmc_state_type;

    typedef struct packed {
        pmc_state_type  st;
        pmc_mode_type   tgt;
        logic [NSUB-1:0]  act_tmpl;
        logic [NSUB-1:0]  alt_tmpl;
        logic [NWAKE-1:0] wake_en;
        logic [NWAKE-1:0] last_wake;
        logic           cpu_force;
        logic [11:0]    cnt;
        logic [31:0]    prdata;
        logic           pready;
        logic           pslverr;
        logic [NSUB-1:0]  subsys_en;
        logic           sys_clk_en;
        logic           lowspeed_clk_en;
        logic           time_wheel_run;
        logic           rtc_run;
        logic           dig_reg_en;
        logic           ana_reg_en;
        logic           hib_reg_en;
        pmc_mode_type   mode_now;
    } pmc_ctrl_state_type;

    pmc_ctrl_state_type s_ff;
    pmc_ctrl_state_type nxt_s;
    logic               buzz;
    logic [NWAKE-1:0]   wake_hit;
    logic               wr_acc;
    logic               setup;
    logic               mode_wr;
    logic [7:0]         addr8;
    pmc_mode_type       req_mode;

    // Regulator pulsing only while asleep
    pmc_buzz u_buzz (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (s_ff.st == ST_SLEEP),
        .pulse   (buzz)
    );

    assign addr8    = 8'(paddr);
    assign setup    = psel && !penable;
    assign wr_acc   = psel && penable && pwrite && s_ff.pready;
    assign mode_wr  = wr_acc && (addr8 == OFF_MODE_SEL);
    assign req_mode = pmc_mode_type'(pwdata[1:0]);
    assign wake_hit = wake_src & s_ff.wake_en;

    always_comb begin
        nxt_s        = s_ff;
        nxt_s.pready = 1'b1;

        // Register access; reads loaded in setup, zero wait state
        if (setup) begin
            nxt_s.pslverr = 1'b0;
            nxt_s.prdata  = 32'h0000_0000;
            case (addr8)
                OFF_MODE_SEL: nxt_s.prdata[1:0] = s_ff.mode_now;
                OFF_ACT_TMPL: nxt_s.prdata[NSUB-1:0] = s_ff.act_tmpl;
                OFF_ALT_TMPL: nxt_s.prdata[NSUB-1:0] = s_ff.alt_tmpl;
                OFF_WAKE_EN:  nxt_s.prdata[NWAKE-1:0] = s_ff.wake_en;
                OFF_STATUS: begin
                    nxt_s.prdata[STAT_MODE_LSB +: 2] = s_ff.mode_now;
                    nxt_s.prdata[STAT_CPU_FORCE]     = s_ff.cpu_force;
                    nxt_s.prdata[STAT_RESUMING]      = (s_ff.st == ST_RESUME);
                    nxt_s.prdata[STAT_WAKE_LSB +: NWAKE] = s_ff.last_wake;
                end
                default: nxt_s.pslverr = 1'b1;
            endcase
        end
        if (wr_acc) begin
            case (addr8)
                OFF_ACT_TMPL: begin
                    nxt_s.act_tmpl  = pwdata[NSUB-1:0];
                    nxt_s.cpu_force = 1'b0;
                end
                OFF_ALT_TMPL: nxt_s.alt_tmpl = pwdata[NSUB-1:0];
                OFF_WAKE_EN:  nxt_s.wake_en  = pwdata[NWAKE-1:0];
                default: ;
            endcase
        end

        // Mode sequencing
        case (s_ff.st)
            ST_ACTIVE, ST_ALT: begin
                if (|wake_hit) begin
                    // Wake wins over a same-cycle mode write and force-clear
                    nxt_s.st        = ST_ACTIVE;
                    nxt_s.cpu_force = 1'b1;
                    nxt_s.last_wake = wake_hit;
                end else if (mode_wr) begin
                    case (req_mode)
                        MODE_ACTIVE:     nxt_s.st = ST_ACTIVE;
                        MODE_ALT_ACTIVE: nxt_s.st = ST_ALT;
                        default: begin
                            nxt_s.st  = ST_ENTER;
                            nxt_s.tgt = req_mode;
                        end
                    endcase
                end
            end
            ST_ENTER: begin
                // System clock already gated; regulators (and for hibernate the low-speed clocks) drop one cycle later
                nxt_s.st = (s_ff.tgt == MODE_SLEEP) ? ST_SLEEP : ST_HIB;
            end
            ST_SLEEP: begin
                if (|wake_hit) begin
                    nxt_s.st        = ST_RESUME;
                    nxt_s.cnt       = 12'(SLEEP_RESUME_CYC - 1);
                    nxt_s.cpu_force = 1'b1;
                    nxt_s.last_wake = wake_hit;
                end
            end
            ST_HIB: begin
                if (wake_hit[WAKE_PIN_IRQ]) begin
                    nxt_s.st        = ST_RESUME;
                    nxt_s.cnt       = 12'(HIB_RESUME_CYC - 1);
                    nxt_s.cpu_force = 1'b1;
                    nxt_s.last_wake = wake_hit & (NWAKE'(1) << WAKE_PIN_IRQ);
                end
            end
            ST_RESUME: begin
                if (s_ff.cnt == 12'h000) begin
                    nxt_s.st = ST_ACTIVE;
                end else begin
                    nxt_s.cnt = s_ff.cnt - 12'h001;
                end
            end
            default: nxt_s.st = ST_ACTIVE;
        endcase

        // Outputs follow the next state so they flip with it
        nxt_s.hib_reg_en      = 1'b1;
        nxt_s.subsys_en       = '0;
        nxt_s.sys_clk_en      = 1'b1;
        nxt_s.lowspeed_clk_en = 1'b1;
        nxt_s.time_wheel_run  = 1'b1;
        nxt_s.rtc_run         = 1'b1;
        nxt_s.dig_reg_en      = 1'b1;
        nxt_s.ana_reg_en      = 1'b1;
        nxt_s.mode_now        = MODE_ACTIVE;
        case (nxt_s.st)
            ST_ACTIVE: begin
                nxt_s.subsys_en = nxt_s.act_tmpl;
                nxt_s.subsys_en[SUB_CPU] = nxt_s.act_tmpl[SUB_CPU] | nxt_s.cpu_force;
            end
            ST_ALT: begin
                nxt_s.subsys_en = nxt_s.alt_tmpl;
                nxt_s.subsys_en[SUB_CPU] = nxt_s.alt_tmpl[SUB_CPU] | nxt_s.cpu_force;
                nxt_s.mode_now  = MODE_ALT_ACTIVE;
            end
            ST_ENTER: begin
                nxt_s.sys_clk_en = 1'b0;
                nxt_s.mode_now   = nxt_s.tgt;
            end
            ST_SLEEP: begin
                nxt_s.sys_clk_en = 1'b0;
                nxt_s.dig_reg_en = buzz;
                nxt_s.ana_reg_en = buzz;
                nxt_s.mode_now   = MODE_SLEEP;
            end
            ST_HIB: begin
                nxt_s.sys_clk_en      = 1'b0;
                nxt_s.lowspeed_clk_en = 1'b0;
                nxt_s.time_wheel_run  = 1'b0;
                nxt_s.rtc_run         = 1'b0;
                nxt_s.dig_reg_en      = 1'b0;
                nxt_s.ana_reg_en      = 1'b0;
                nxt_s.mode_now        = MODE_HIBERNATE;
            end
            default: ; // Resume: clocks and regulators on, subsystems held off
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff                 <= '0;
            s_ff.st              <= ST_ACTIVE;
            s_ff.act_tmpl        <= RST_ACT_TMPL[NSUB-1:0];
            s_ff.alt_tmpl        <= RST_ALT_TMPL[NSUB-1:0];
            s_ff.wake_en         <= RST_WAKE_EN[NWAKE-1:0];
            s_ff.subsys_en       <= RST_ACT_TMPL[NSUB-1:0];
            s_ff.sys_clk_en      <= 1'b1;
            s_ff.lowspeed_clk_en <= 1'b1;
            s_ff.time_wheel_run  <= 1'b1;
            s_ff.rtc_run         <= 1'b1;
            s_ff.dig_reg_en      <= 1'b1;
            s_ff.ana_reg_en      <= 1'b1;
            s_ff.hib_reg_en      <= 1'b1;
            s_ff.pready          <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign prdata          = s_ff.prdata;
    assign pready          = s_ff.pready;
    assign pslverr         = s_ff.pslverr;
    assign subsys_en       = s_ff.subsys_en;
    assign sys_clk_en      = s_ff.sys_clk_en;
    assign lowspeed_clk_en = s_ff.lowspeed_clk_en;
    assign time_wheel_run  = s_ff.time_wheel_run;
    assign rtc_run         = s_ff.rtc_run;
    assign dig_reg_en      = s_ff.dig_reg_en;
    assign ana_reg_en      = s_ff.ana_reg_en;
    assign hib_reg_en      = s_ff.hib_reg_en;
    assign mode_now        = s_ff.mode_now;

    // Helper: cycles spent in the current resume, cleared one cycle after it ends
    logic [12:0] res_len_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_len_ff <= 13'h0000;
        end else if (s_ff.st == ST_RESUME) begin
            res_len_ff <= res_len_ff + 13'h0001;
        end else begin
            res_len_ff <= 13'h0000;
        end
    end
    logic from_hib_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            from_hib_ff <= 1'b0;
        end else if (s_ff.st == ST_HIB || s_ff.st == ST_SLEEP) begin
            from_hib_ff <= (s_ff.st == ST_HIB);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_mode_map;
        (s_ff.st == ST_SLEEP) |-> (mode_now == MODE_SLEEP) && !sys_clk_en && hib_reg_en;
    endproperty
    a_mode_map: assert property (p_mode_map) else $error("sleep mode map wrong");

    property p_act_tmpl;
        (s_ff.st == ST_ACTIVE) |-> subsys_en[NSUB-1:1] == s_ff.act_tmpl[NSUB-1:1];
    endproperty
    a_act_tmpl: assert property (p_act_tmpl) else $error("active template not applied");

    property p_alt_tmpl;
        (s_ff.st == ST_ALT) |-> subsys_en[NSUB-1:1] == s_ff.alt_tmpl[NSUB-1:1];
    endproperty
    a_alt_tmpl: assert property (p_alt_tmpl) else $error("alternate template not applied");

    property p_sleep_off;
        (s_ff.st == ST_SLEEP) |-> (subsys_en == '0) && time_wheel_run && rtc_run
            && lowspeed_clk_en;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("sleep resources wrong");

    property p_buzz;
        (s_ff.st == ST_SLEEP && $rose(dig_reg_en))
            |=> dig_reg_en[*3] ##1 (!dig_reg_en || s_ff.st != ST_SLEEP);
    endproperty
    a_buzz: assert property (p_buzz) else $error("regulator pulse length wrong");

    property p_hib;
        (s_ff.st == ST_HIB) |-> !sys_clk_en && !lowspeed_clk_en && !dig_reg_en
            && !ana_reg_en && hib_reg_en && (subsys_en == '0) && $stable(s_ff.act_tmpl);
    endproperty
    a_hib: assert property (p_hib) else $error("hibernate gating wrong");

    property p_hib_pin_only;
        (s_ff.st == ST_HIB && !wake_src[WAKE_PIN_IRQ]) |=> s_ff.st == ST_HIB;
    endproperty
    a_hib_pin_only: assert property (p_hib_pin_only) else $error("hibernate left without pin");

    property p_cpu_force;
        (s_ff.st == ST_ACTIVE && s_ff.cpu_force) |-> subsys_en[SUB_CPU];
    endproperty
    a_cpu_force: assert property (p_cpu_force) else $error("cpu not forced on");

    property p_sleep_resume;
        (s_ff.st == ST_ACTIVE && $past(s_ff.st) == ST_RESUME && !from_hib_ff)
            |-> res_len_ff == 13'(SLEEP_RESUME_CYC);
    endproperty
    a_sleep_resume: assert property (p_sleep_resume) else $error("sleep resume length");

    property p_hib_resume;
        (s_ff.st == ST_RESUME) |-> res_len_ff < 13'(HIB_RESUME_CYC);
    endproperty
    a_hib_resume: assert property (p_hib_resume) else $error("resume too long");

    property p_no_auto;
        (s_ff.st == ST_ACTIVE && !mode_wr) |=> s_ff.st == ST_ACTIVE;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("left active without write");

    sequence s_low_req;
        (s_ff.st == ST_ACTIVE || s_ff.st == ST_ALT) && mode_wr && !(|wake_hit)
            && (req_mode == MODE_SLEEP);
    endsequence
    sequence s_gate_order;
        (s_ff.st == ST_ENTER && !sys_clk_en && subsys_en == '0 && dig_reg_en)
            ##1 (s_ff.st == ST_SLEEP);
    endsequence
    property p_entry;
        s_low_req |=> s_gate_order;
    endproperty
    a_entry: assert property (p_entry) else $error("sleep entry order wrong");

    sequence s_wake_sleep;
        s_ff.st == ST_SLEEP && (|wake_hit);
    endsequence
    property p_wake;
        s_wake_sleep |=> (s_ff.st == ST_RESUME && mode_now == MODE_ACTIVE);
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not resume");

    property p_hib_clk;
        (s_ff.st == ST_HIB) |-> !time_wheel_run && !rtc_run;
    endproperty
    a_hib_clk: assert property (p_hib_clk) else $error("timers run in hibernate");
endmodule

// *** tb/pmc_power_mode_ctrl_tb.sv ***
`timescale 1ns/1ps
module pmc_power_mode_ctrl_tb;
    import pmc_pkg::*;

    typedef struct {
        logic        rd;
        logic [31:0] data;
        logic        err;
    } pmc_note_type;

    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic [5:0]    wake_src;
    logic [7:0]    subsys_en;
    logic          sys_clk_en;
    logic          lowspeed_clk_en;
    logic          time_wheel_run;
    logic          rtc_run;
    logic          dig_reg_en;
    logic          ana_reg_en;
    logic          hib_reg_en;
    pmc_mode_type  mode_now;
    logic [6:0]    ens;
    int            err_count;
    int            compares;
    int            cycles;
    int            cnt;
    int            dig_cnt;
    int            ana_cnt;
    logic [6:0]    keep_and;
    logic [6:0]    keep_or;
    logic [7:0]    act;
    logic [7:0]    alt;
    pmc_note_type  notes[$];
    pmc_note_type  nt;
    int            others[5] = '{0, 2, 3, 4, 5};

    // Enables gathered: sys, lowspeed, wheel, rtc, dig, ana, hib
    assign ens = {sys_clk_en, lowspeed_clk_en, time_wheel_run, rtc_run, dig_reg_en, ana_reg_en,
                  hib_reg_en};

    pmc_power_mode_ctrl uut (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .wake_src        (wake_src),
        .subsys_en       (subsys_en),
        .sys_clk_en      (sys_clk_en),
        .lowspeed_clk_en (lowspeed_clk_en),
        .time_wheel_run  (time_wheel_run),
        .rtc_run         (rtc_run),
        .dig_reg_en      (dig_reg_en),
        .ana_reg_en      (ana_reg_en),
        .hib_reg_en      (hib_reg_en),
        .mode_now        (mode_now)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Note goes on the queue before the request, the monitor judges the answer
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        notes.push_back('{rd: !wr, data: exp, err: err});
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a slave that never answers
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (notes.size() == 0) begin
                check("unexpected transfer", 32'h0000_0001, 32'h0000_0000);
            end else begin
                nt = notes.pop_front();
                if (nt.rd) check("prdata", prdata, nt.data);
                check("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
            end
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles > 12000) begin
            err_count++;
            wrap_up();
        end
    end

    // Wake edge is the one that clears the pulse
    task automatic pulse(input int idx);
        @(posedge pclk);
        wake_src <= 6'(1 << idx);
        @(posedge pclk);
        wake_src <= 6'h00;
    endtask

    task automatic wake_wait(input int idx, output int n);
        pulse(idx);
        n = 0;
        while (subsys_en === 8'h00 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        #1;
    endtask

    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        wake_src = 6'h00;
        presetn = 1'b0;
        void'($urandom(15933));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        check("mode_now", {30'h0, mode_now}, {30'h0, MODE_ACTIVE});
        check("subsys_en", {24'h0, subsys_en}, 32'h0000_00FF);
        check("enables", {25'h0, ens}, 32'h0000_007F);
        apb(1'b0, OFF_ACT_TMPL, 32'h0, 32'h0000_00FF, 1'b0);
        apb(1'b0, OFF_ALT_TMPL, 32'h0, 32'h0000_0000, 1'b0);
        apb(1'b0, OFF_WAKE_EN, 32'h0, 32'h0000_003F, 1'b0);
        apb(1'b1, 8'h14, 32'hFFFF_FFFF, 32'h0, 1'b1);
        apb(1'b0, 8'h14, 32'h0, 32'h0000_0000, 1'b1);
        apb(1'b0, OFF_MODE_SEL, 32'h0, 32'h0000_0000, 1'b0);
        // Processor switched off by its own template bit
        act = (8'($urandom()) & 8'hFE) | 8'h02;
        apb(1'b1, OFF_ACT_TMPL, {24'h0, act}, 32'h0, 1'b0);
        #1;
        check("subsys_en", {24'h0, subsys_en}, {24'h0, act});
        for (int i = 0; i < 4; i++) begin
            pulse(int'($urandom_range(5, 0)));
            settle();
            check("mode_now", {30'h0, mode_now}, {30'h0, MODE_ACTIVE});
            check("subsys_en", {24'h0, subsys_en}, {24'h0, act | 8'h01});
        end
        apb(1'b1, OFF_ACT_TMPL, {24'h0, act}, 32'h0, 1'b0);
        alt = 8'($urandom());
        apb(1'b1, OFF_ALT_TMPL, {24'h0, alt}, 32'h0, 1'b0);
        for (int m = 1; m >= 0; m--) begin
            apb(1'b1, OFF_MODE_SEL, 32'(m), 32'h0, 1'b0);
            #1;
            check("mode_now", {30'h0, mode_now}, 32'(m));
            check("subsys_en", {24'h0, subsys_en}, {24'h0, (m == 1) ? alt : act});
        end
        apb(1'b1, OFF_MODE_SEL, 32'h1, 32'h0, 1'b0);
        pulse(3);
        settle();
        check("mode_now", {30'h0, mode_now}, {30'h0, MODE_ACTIVE});
        check("subsys_en", {24'h0, subsys_en}, {24'h0, act | 8'h01});
        // Sleep: system clock drops on the write edge, regulators one edge later
        apb(1'b1, OFF_MODE_SEL, 32'h2, 32'h0, 1'b0);
        #1;
        check("mode_now", {30'h0, mode_now}, {30'h0, MODE_SLEEP});
        check("subsys_en", {24'h0, subsys_en}, 32'h0);
        check("sys_clk_en", {31'h0, sys_clk_en}, 32'h0);
        check("dig_reg_en", {31'h0, dig_reg_en}, 32'h1);
        @(posedge pclk);
        keep_and = 7'h7F;
        keep_or = 7'h00;
        dig_cnt = 0;
        ana_cnt = 0;
        for (int i = 0; i < 128; i++) begin
            @(posedge pclk);
            #1;
            keep_and &= ens;
            keep_or |= ens;
            dig_cnt += int'(dig_reg_en === 1'b1);
            ana_cnt += int'(ana_reg_en === 1'b1);
        end
        check("timers on", {25'h0, keep_and & 7'h38}, 32'h38);
        check("sys clock seen", {31'h0, keep_or[6]}, 32'h0);
        check("dig pulses", 32'(dig_cnt), 32'(2 * BUZZ_ON_CYC));
        check("ana pulses", 32'(ana_cnt), 32'(2 * BUZZ_ON_CYC));
        wake_wait(WAKE_COMPARATOR, cnt);
        check("sleep resume", {31'h0, cnt >= 598 && cnt <= 603}, 32'h1);
        check("mode_now", {30'h0, mode_now}, {30'h0, MODE_ACTIVE});
        check("subsys_en", {24'h0, subsys_en}, {24'h0, act | 8'h01});
        // Hibernate: only the pin interrupt source may end it
        apb(1'b1, OFF_MODE_SEL, 32'h3, 32'h0, 1'b0);
        #1;
        check("mode_now", {30'h0, mode_now}, {30'h0, MODE_HIBERNATE});
        check("sys_clk_en", {31'h0, sys_clk_en}, 32'h0);
        check("dig_reg_en", {31'h0, dig_reg_en}, 32'h1);
        @(posedge pclk);
        #1;
        check("enables", {25'h0, ens}, 32'h0000_0001);
        check("subsys_en", {24'h0, subsys_en}, 32'h0);
        foreach (others[i]) begin
            pulse(others[i]);
            settle();
            check("mode_now", {30'h0, mode_now}, {30'h0, MODE_HIBERNATE});
            check("enables", {25'h0, ens}, 32'h0000_0001);
        end
        wake_wait(WAKE_PIN_IRQ, cnt);
        check("hib resume", {31'h0, cnt >= 3998 && cnt <= 4003}, 32'h1);
        check("mode_now", {30'h0, mode_now}, {30'h0, MODE_ACTIVE});
        check("enables", {25'h0, ens}, 32'h0000_007F);
        apb(1'b0, OFF_ACT_TMPL, 32'h0, {24'h0, act}, 1'b0);
        apb(1'b0, OFF_ALT_TMPL, 32'h0, {24'h0, alt}, 1'b0);
        repeat (2) @(posedge pclk);
        check("notes left", 32'(notes.size()), 32'h0);
        wrap_up();
    end
endmodule
